// >>> led_pwm_fault_serial_ctrl.sv
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module led_pwm_fault_serial_ctrl
  import led_pwm_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // device pins
  input  wire pin_in_t     pins,
  output logic [15:0]      sink_channel,
  output logic             serial_out,
  output logic             fault_out_n,
  output logic             fault_out_n_oe,
  // axi4-lite write
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  logic [PIN_W-1:0]   sync1;
  logic [PIN_W-1:0]   sync2;
  logic [PIN_W-1:0]   sync3;
  pin_in_t            filt;
  pin_in_t            filt_d;
  logic               pwm_rise;
  logic               pwm_fall;
  logic               shift_rise;
  logic               shift_fall;
  logic               latch_rise;
  logic               latch_fall;
  logic               ext_active;
  logic               half_len;
  logic [11:0]        gs_cnt;
  logic [11:0]        gs [NCH];
  logic [15:0]        chan_on;
  logic [15:0]        lod_active;
  logic [15:0]        open_led_flag;
  logic [15:0]        auto_off;
  logic [15:0]        chan_mask;
  logic [15:0]        dly [DLY_LEN];
  logic               cap33;
  logic               off33;
  logic               over_temp_flag;
  logic               tef_pend;
  logic               sid_pend;
  logic               shifted;
  bank_t              bank;
  logic [191:0]       sr;
  logic [191:0]       next_sr;
  logic [95:0]        dot_correction;
  logic               aw_got;
  logic               w_got;
  logic [7:0]         aw_ofs;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic [32:0]        rd_word;
  logic [32:0]        wr_word;

  // msb of the active shift length, used for serial output
  function automatic logic sr_msb(input logic [191:0] v, input logic half);
    sr_msb = half ? v[HALF_LEN-1] : v[FULL_LEN-1];
  endfunction

  // register read decode
  function automatic logic [32:0] reg_read(input logic [7:0] ofs, input logic [191:0] unused_sr);
    reg_read = {1'b0, 32'h0000_0000};
    case (ofs)
      CHAN_MASK_OFS: reg_read[15:0] = chan_mask;
      STATUS_OFS:    reg_read[19:0] = {bank, ext_active, over_temp_flag, open_led_flag};
      COUNT_OFS:     reg_read[11:0] = gs_cnt;
      DOTC0_OFS:     reg_read[31:0] = dot_correction[31:0];
      DOTC1_OFS:     reg_read[31:0] = dot_correction[63:32];
      DOTC2_OFS:     reg_read[31:0] = dot_correction[95:64];
      default:       reg_read[32] = 1'b1;
    endcase
  endfunction

  // three-stage pin synchroniser; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1[gi] <= PIN_RST[gi];
          sync2[gi] <= PIN_RST[gi];
          sync3[gi] <= PIN_RST[gi];
        end
        else
        begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  // filtered pins; blanking resets high so outputs stay off until released
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt   <= PIN_RST;
      filt_d <= PIN_RST;
    end
    else
    begin
      for (int i = 0; i < PIN_W; i++)
        if (sync2[i] == sync3[i])
          filt[i] <= sync3[i];
      filt_d <= filt;
    end
  end

  assign pwm_rise   = filt.pwm_ref_clock & ~filt_d.pwm_ref_clock;
  assign pwm_fall   = ~filt.pwm_ref_clock & filt_d.pwm_ref_clock;
  assign shift_rise = filt.shift_clock & ~filt_d.shift_clock;
  assign shift_fall = ~filt.shift_clock & filt_d.shift_clock;
  assign latch_rise = filt.latch_strobe & ~filt_d.latch_strobe;
  assign latch_fall = ~filt.latch_strobe & filt_d.latch_strobe;
  assign ext_active = ~filt.extended_iface_sel_n & ~filt.mode_dc; // R16 R21
  assign half_len   = filt.mode_dc | ext_active; // R14
  assign cap33      = pwm_rise & ~filt.blank & (gs_cnt == LOD_EDGE - 12'h0001);
  assign off33      = pwm_fall & ~filt.blank & (gs_cnt == LOD_EDGE);
  assign rd_word    = reg_read(araddr[7:0], sr); // bit 32 flags an unmapped offset
  assign wr_word    = reg_read(aw_ofs, sr);

  // grayscale counter: held at zero under blanking, saturates at full scale
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gs_cnt <= 12'h0000;
    else if (filt.blank)
      gs_cnt <= 12'h0000; // R11
    else if (pwm_rise && gs_cnt != CNT_MAX)
      gs_cnt <= gs_cnt + 12'h0001; // R23
  end

  // channel on-state; full scale stops the cycle until the next one
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      chan_on[i] = ~filt.blank & (gs_cnt != 12'h0000) & (gs_cnt != CNT_MAX)
                   & (gs_cnt <= gs[i]) & ~auto_off[i] & ~chan_mask[i]; // R11 R12 R23
      lod_active[i] = (gs[i] >= LOD_EDGE) & ~auto_off[i] & ~chan_mask[i]; // R2
    end
  end

  // open-led capture and automatic shut-off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      open_led_flag <= 16'h0000;
      auto_off      <= 16'h0000;
    end
    else
    begin
      if (cap33)
        open_led_flag <= lod_active & filt.low_volt_detect; // R1 R2 R3
      if (filt.blank)
        auto_off <= 16'h0000; // R27
      else if (off33)
        auto_off <= auto_off | open_led_flag; // R5
    end
  end

  // staggered group outputs; blanking gates at the source so a late group may trail it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int s = 0; s < DLY_LEN; s++)
        dly[s] <= 16'h0000;
    else
    begin
      dly[0] <= chan_on;
      for (int s = 1; s < DLY_LEN; s++)
        dly[s] <= dly[s-1]; // R10
    end
  end

  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_sink
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          sink_channel[gi] <= 1'b0;
        else
          sink_channel[gi] <= dly[(gi % NGRP) * GROUP_STEP][gi]; // R9 R10
      end
    end
  endgenerate

  // thermal flag: a hot die always wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      over_temp_flag <= 1'b0;
      tef_pend       <= 1'b0;
    end
    else
    begin
      if (latch_fall)
        tef_pend <= 1'b1;
      else if (shift_fall)
        tef_pend <= 1'b0;
      if (shift_fall && tef_pend)
        over_temp_flag <= filt.over_temp; // R8
      else if (filt.over_temp)
        over_temp_flag <= 1'b1; // R7
    end
  end

  // open-drain fault output, pulled low while enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_out_n    <= 1'b0;
      fault_out_n_oe <= 1'b0;
    end
    else
    begin
      fault_out_n    <= 1'b0;
      fault_out_n_oe <= over_temp_flag | ((|open_led_flag) & ~filt.blank); // R7 R26
    end
  end

  // next shift value, with status overwrite on the first edge after latch
  always_comb
  begin
    next_sr = {sr[FULL_LEN-2:0], filt.serial_in}; // R24
    if (sid_pend && !filt.mode_dc && (!ext_active || bank == bank_high)) // R20 R25
    begin
      if (half_len)
        next_sr[HALF_LEN-1 -: SID_W] = {open_led_flag, over_temp_flag};
      else
        next_sr[FULL_LEN-1 -: SID_W] = {open_led_flag, over_temp_flag};
    end
  end

  // shift register, latches and half-bank selection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sr             <= '0;
      sid_pend       <= 1'b0;
      shifted        <= 1'b0;
      bank           <= bank_none;
      dot_correction <= '0;
      for (int i = 0; i < NCH; i++)
        gs[i] <= 12'h000;
    end
    else
    begin
      if (shift_rise)
      begin
        sr       <= next_sr;
        sid_pend <= 1'b0;
        shifted  <= 1'b1;
      end
      else if (latch_fall)
        sid_pend <= 1'b1;
      if (latch_rise)
      begin
        if (shifted)
        begin
          shifted <= 1'b0;
          bank    <= bank_none;
          if (filt.mode_dc)
            dot_correction <= sr[HALF_LEN-1:0]; // R14 R21
          else if (ext_active)
          begin
            for (int j = 0; j < HALF_CH; j++)
              gs[(bank == bank_high ? HALF_CH : 0) + j] <= sr[j*GS_W +: GS_W]; // R17
          end
          else
            for (int i = 0; i < NCH; i++)
              gs[i] <= sr[i*GS_W +: GS_W]; // R24
        end
        else if (ext_active && filt.blank)
          bank <= (bank == bank_none) ? bank_low : bank_high; // R17
      end
    end
  end

  // serial output: prompt in normal mode, half a shift clock later in extended mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_out <= 1'b0;
    else if (!ext_active || shift_fall)
      serial_out <= sr_msb(sr, half_len); // R13 R19
  end

  // axi4-lite write channel; address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_ofs    <= 8'h00;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      chan_mask <= 16'h0000;
    end
    else
    begin
      awready <= awvalid & ~awready & ~aw_got & ~bvalid;
      wready  <= wvalid & ~wready & ~w_got & ~bvalid;
      if (awvalid && awready)
      begin
        aw_got <= 1'b1;
        aw_ofs <= awaddr[7:0];
      end
      if (wvalid && wready)
      begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (aw_got && w_got && !bvalid)
      begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= RESP_OKAY;
        if (aw_ofs == CHAN_MASK_OFS)
        begin
          if (w_strb[0])
            chan_mask[7:0] <= w_data[7:0];
          if (w_strb[1])
            chan_mask[15:8] <= w_data[15:8];
        end
        else if (wr_word[32])
          bresp <= RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // axi4-lite read channel; unmapped reads return zero with an error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      arready <= arvalid & ~arready & ~rvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_word[31:0];
        rresp  <= rd_word[32] ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  lod_capture_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    cap33 |=> open_led_flag == ($past(lod_active) & $past(filt.low_volt_detect)))
    else $error("open-led flags not captured at edge 33");
  lod_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    !cap33 |=> $stable(open_led_flag))
    else $error("open-led flags changed between captures");
  lod_inactive_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    cap33 |=> (open_led_flag & ~$past(lod_active)) == 16'h0000)
    else $error("inactive channel reported open");
  auto_off_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    off33 |=> (auto_off & $past(open_led_flag)) == $past(open_led_flag))
    else $error("faulty channel not switched off");
  auto_off_keep_a: assert property (@(posedge aclk) disable iff (!aresetn) // R27
    (!filt.blank && auto_off != 16'h0000) |=> (auto_off & $past(auto_off)) == $past(auto_off))
    else $error("auto shut-off released before blanking");
  temp_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    filt.over_temp |=> over_temp_flag ##1 fault_out_n_oe)
    else $error("over-temperature did not raise flag and fault");
  blank_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    filt.blank |=> gs_cnt == 12'h0000 && chan_on == 16'h0000)
    else $error("blanking did not hold counter and outputs");
  count_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // R23
    (pwm_rise && !filt.blank && gs_cnt != CNT_MAX && !$past(filt.blank)) |=>
      (filt.blank || gs_cnt == $past(gs_cnt) + 12'h0001))
    else $error("grayscale counter did not step");
  group_skew_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    sink_channel[1] == $past(dly[GROUP_STEP][1]))
    else $error("group one not delayed by one step");
  fault_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) // R26
    (filt.blank && !over_temp_flag) |=> !fault_out_n_oe)
    else $error("open-led fault not masked by blanking");

endmodule

// >>> led_pwm_pkg.sv
// Notes on behaviour
// R1: open-led flags captured at the 33rd rising pwm edge, held until the next.
// R2: only channels on at that edge are checked; others report no fault.
// R3: flag is 1 when the low-voltage detect is high at the edge, else 0.
// R4: controller should program grayscale 21h or more for per-cycle detection.
// R5: faulty channels switch off at the 33rd falling pwm edge after blanking falls.
// R6: controller should program grayscale 0 for unconnected channels.
// R7: over-temperature sets the thermal flag and pulls the fault output low.
// R8: thermal flag clears at first falling shift edge after latch low, unless still hot.
// R9: group k holds channels k, k+4, k+8, k+12.
// R10: groups switch one after another with a short delay, on and off.
// R11: blanking high forces outputs off and holds the counter at zero.
// R12: short blanking-low gives the shorter of grayscale count and blanking-low time.
// R13: serial output feeds next device serial input, forming one long chain.
// R14: mode low gives a 192-bit grayscale register, high a 96-bit dot-correction one.
// R15: controller keeps latch strobe low while changing mode.
// R16: select input low enables half-bank access and half-clock-delayed serial output.
// R17: in extended mode latch pulses under blanking select low or high half-bank.
// R18: controller gives one or two latch pulses under blanking before shifting.
// R19: extended mode: serial output changes on falling shift edges, input on rising.
// R20: extended mode: status appears only in upper half-bank transfers.
// R21: extended operation only in grayscale mode; mode high is plain dot-correction.
// R22: controller keeps blanking high until data are loaded.
// R23: 12-bit counter counts rising pwm edges; channel on while counter within value.
// R24: data shift in msb first on rising shift edges, latch on rising strobe.
// R25: status overwrites top 17 shift bits at first rising shift edge after latch low.
// R26: fault output shows thermal fault always, open-led faults only while unblanked.
// R27: auto shut-off holds until blanking starts a new cycle.
package led_pwm_pkg;
  localparam int NCH            = 16;
  localparam int GS_W           = 12;
  localparam int NGRP           = 4;
  localparam int FULL_LEN       = 192;
  localparam int HALF_LEN       = 96;
  localparam int SID_W          = 17;
  localparam int HALF_CH        = 8;
  localparam logic [11:0] CNT_MAX   = 12'h0fff;
  localparam logic [11:0] LOD_EDGE  = 12'h0021;
  localparam int CLK_MHZ        = 250;
  localparam int GROUP_DELAY_NS = 8;
  localparam int GROUP_STEP     = (GROUP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY_LEN        = (NGRP - 1) * GROUP_STEP + 1;
  // register byte offsets
  localparam logic [7:0] CHAN_MASK_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] COUNT_OFS     = 8'h08;
  localparam logic [7:0] DOTC0_OFS     = 8'h0c;
  localparam logic [7:0] DOTC1_OFS     = 8'h10;
  localparam logic [7:0] DOTC2_OFS     = 8'h14;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam int PIN_W          = 24;

  typedef enum logic [1:0] {
    bank_none = 2'b00,
    bank_low  = 2'b01,
    bank_high = 2'b10
  } bank_t;

  typedef struct packed {
    logic        pwm_ref_clock;
    logic        shift_clock;
    logic        latch_strobe;
    logic        blank;
    logic        serial_in;
    logic        mode_dc;
    logic        extended_iface_sel_n;
    logic        over_temp;
    logic [15:0] low_volt_detect;
  } pin_in_t;

  // pin levels held through reset: blanked, extended select off, so no false edge follows release
  localparam pin_in_t PIN_RST = '{blank: 1'b1, extended_iface_sel_n: 1'b1, default: '0};
endpackage

// >>> serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model
  import led_pwm_pkg::*;
(
  // clock
  input  wire logic aclk,
  // device pins
  output pin_in_t   pins,
  input  wire logic serial_out
);
  localparam int HALF = 4; // half of the 32 ns link period
  logic [191:0] got;

  // blank high from the start keeps sinks dark until data are loaded
  initial
  begin
    pins = '0;
    pins.blank = 1'b1;
    pins.extended_iface_sel_n = 1'b1;
    got = '0;
  end

  task automatic tick();
    repeat (HALF) @(posedge aclk);
  endtask

  // msb first; serial_out is read late in the low phase, where it has settled
  task automatic shift_bits(input logic [191:0] data, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      pins.serial_in <= data[i];
      tick();
      got = {got[190:0], serial_out};
      pins.shift_clock <= 1'b1;
      tick();
      pins.shift_clock <= 1'b0;
    end
    pins.serial_in <= ~data[0]; // idle line shows the inverse, never a stale bit
    tick();
  endtask

  // one strobe pulse, wide enough for the pin filter
  task automatic latch_pulse();
    pins.latch_strobe <= 1'b1;
    tick();
    pins.latch_strobe <= 1'b0;
    tick();
  endtask

  // pulses, then time for the pin filter and the group delays to settle
  task automatic pwm(input int n);
    repeat (n)
    begin
      pins.pwm_ref_clock <= 1'b1;
      tick();
      pins.pwm_ref_clock <= 1'b0;
      tick();
    end
    repeat (16) @(posedge aclk);
  endtask

  // mode only changes here, while the strobe rests low
  task automatic set_ctrl(input logic bl, input logic dc, input logic sel_n, input logic ot, input logic [15:0] lvd);
    @(posedge aclk);
    pins.blank <= bl;
    pins.mode_dc <= dc;
    pins.extended_iface_sel_n <= sel_n;
    pins.over_temp <= ot;
    pins.low_volt_detect <= lvd;
    // pin filter plus the last group's delay must pass before anyone looks
    repeat (16) @(posedge aclk);
  endtask
endmodule

// >>> led_pwm_fault_serial_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin miscompares++; $display("ERROR %s expected %h seen %h", nm, ex, sn); end end
module led_pwm_fault_serial_ctrl_tb
  import led_pwm_pkg::*;
;
  logic         aclk, aresetn;
  pin_in_t      pins;
  logic [15:0]  sink_channel, mask;
  logic         serial_out, fault_out_n, fault_out_n_oe;
  logic [31:0]  awaddr, wdata, araddr, rdata;
  logic [3:0]   wstrb;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic [1:0]   bresp, rresp, rs;
  logic [2:0]   prot;
  logic [191:0] frame_a;
  int           miscompares, n_compared;
  int           gs [16];

  led_pwm_fault_serial_ctrl dut (.aclk(aclk), .aresetn(aresetn), .pins(pins), .sink_channel(sink_channel),
    .serial_out(serial_out), .fault_out_n(fault_out_n), .fault_out_n_oe(fault_out_n_oe),
    .awaddr(awaddr), .awprot(prot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(prot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  serial_host_model host (.aclk(aclk), .pins(pins), .serial_out(serial_out));

  // 250 MHz clock
  initial
    aclk = 1'b0;
  always #2 aclk = ~aclk;

  // expected sinks after n pwm pulses, given channels cut off by faults
  function automatic logic [15:0] exp_on(input int n, input logic [15:0] off);
    for (int i = 0; i < 16; i++)
      exp_on[i] = (n >= 1) && (n <= gs[i]) && !off[i] && !mask[i];
  endfunction

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      ad = ad | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
      awvalid <= !ad;
      wvalid <= !wd;
    end
    while (!(ad && wd));
    do
      @(posedge aclk);
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    `CHK(nm, ed, d)
    `CHK(nm, er, r)
  endtask

  // a hang ends the run as a failure
  initial
  begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    aresetn = 1'b0;
    {awaddr, wdata, araddr} = '0;
    prot = 3'h0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    mask = 16'h8000;
    for (int i = 0; i < 16; i++)
    begin
      gs[i] = 16 + 2 * i;
      frame_a[12*i +: 12] = 12'(gs[i]);
    end
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(STATUS_OFS, 32'h0000_0000, RESP_OKAY, "status reset");
    rd_chk(8'h40, 32'h0000_0000, RESP_SLVERR, "unmapped read");
    axi_wr(8'h40, 32'h0000_0001, rs);
    `CHK("unmapped write", RESP_SLVERR, rs)
    axi_wr(STATUS_OFS, 32'hffff_ffff, rs);
    `CHK("read-only write", RESP_OKAY, rs)
    rd_chk(STATUS_OFS, 32'h0000_0000, RESP_OKAY, "read-only kept");
    wstrb <= 4'h2; // only the upper mask byte may change
    axi_wr(CHAN_MASK_OFS, 32'h0000_40ff, rs);
    rd_chk(CHAN_MASK_OFS, 32'h0000_4000, RESP_OKAY, "mask lane");
    wstrb <= 4'hf;
    prot <= 3'h2; // protection bits are ignored
    axi_wr(CHAN_MASK_OFS, {16'h0000, mask}, rs);
    rd_chk(CHAN_MASK_OFS, {16'h0000, mask}, RESP_OKAY, "mask");
    `CHK("fault data", 1'b0, fault_out_n)
    host.shift_bits(frame_a, 192);
    host.latch_pulse();
    host.set_ctrl(1'b0, 1'b0, 1'b1, 1'b0, 16'h0a05);
    // the first pulse shows group 0 alone, the last group six cycles later
    fork
      host.pwm(1);
      begin
        for (int k = 0; k < 40 && sink_channel === 16'h0000; k++)
          @(posedge aclk);
        `CHK("first group", exp_on(1, 16'h0000) & 16'h1111, sink_channel)
        repeat (6) @(posedge aclk);
        `CHK("all groups", exp_on(1, 16'h0000), sink_channel)
      end
    join
    host.pwm(19);
    `CHK("on at 20", exp_on(20, 16'h0000), sink_channel)
    host.pwm(13);
    `CHK("on at 33", exp_on(33, 16'h0a00), sink_channel)
    rd_chk(STATUS_OFS, 32'h0000_0a00, RESP_OKAY, "open flags");
    `CHK("fault open", 1'b1, fault_out_n_oe)
    host.pwm(2);
    `CHK("cut off held", exp_on(35, 16'h0a00), sink_channel)
    rd_chk(COUNT_OFS, 32'h0000_0023, RESP_OKAY, "count");
    host.set_ctrl(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000);
    `CHK("blank off", 16'h0000, sink_channel)
    `CHK("open masked", 1'b0, fault_out_n_oe)
    rd_chk(COUNT_OFS, 32'h0000_0000, RESP_OKAY, "count blank");
    host.set_ctrl(1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
    `CHK("fault temp", 1'b1, fault_out_n_oe)
    host.set_ctrl(1'b1, 1'b0, 1'b1, 1'b0, 16'h0000);
    rd_chk(STATUS_OFS, 32'h0001_0a00, RESP_OKAY, "temp sticky");
    host.shift_bits(frame_a, 192);
    `CHK("chain out", {16'h0a00, 1'b1, frame_a[173:0]}, host.got[190:0])
    host.latch_pulse();
    rd_chk(STATUS_OFS, 32'h0000_0a00, RESP_OKAY, "temp cleared");
    host.set_ctrl(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
    host.pwm(20);
    `CHK("re-enabled", exp_on(20, 16'h0000), sink_channel)
    rd_chk(STATUS_OFS, 32'h0000_0a00, RESP_OKAY, "flags held");
    host.pwm(13);
    rd_chk(STATUS_OFS, 32'h0000_0000, RESP_OKAY, "flags renewed");
    // dot-correction with the extended select low still acts as plain mode
    host.set_ctrl(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
    host.shift_bits({96'h0, 96'h0123_4567_89ab_cdef_0f1e_2d3c}, 96);
    host.latch_pulse();
    rd_chk(DOTC0_OFS, 32'h0f1e_2d3c, RESP_OKAY, "dc low");
    rd_chk(DOTC1_OFS, 32'h89ab_cdef, RESP_OKAY, "dc mid");
    rd_chk(DOTC2_OFS, 32'h0123_4567, RESP_OKAY, "dc high");
    rd_chk(STATUS_OFS, 32'h0000_0000, RESP_OKAY, "dc not extended");
    host.set_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
    host.latch_pulse();
    rd_chk(STATUS_OFS, 32'h0006_0000, RESP_OKAY, "bank low");
    host.latch_pulse();
    rd_chk(STATUS_OFS, 32'h000a_0000, RESP_OKAY, "bank high");
    host.shift_bits(192'h0, 96);
    host.latch_pulse();
    rd_chk(STATUS_OFS, 32'h0002_0000, RESP_OKAY, "bank none");
    host.set_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    host.pwm(1);
    `CHK("half bank", 16'h00ff, sink_channel)
    wrap_up();
  end
endmodule
